//--- ccpw_defs.svh
// Constants of the standard PWM unit
`ifndef CCPW_DEFS_SVH
`define CCPW_DEFS_SVH

`define CCPW_ADDR_CTRL 4'h0
`define CCPW_ADDR_DUTY 4'h4
`define CCPW_ADDR_DIR 4'h8
`define CCPW_ADDR_STAT 4'hc
`define CCPW_EN_BIT 7
`define CCPW_OUT_BIT 5
`define CCPW_FMT_BIT 4
`define CCPW_MODE_PWM 2'b11
`define CCPW_MODE_HI 3
`define CCPW_MODE_LO 2
`define CCPW_CTRL_RST 8'h00
`define CCPW_DUTY_RST 16'h0000
`define CCPW_DIR_RST 1'b1
`define CCPW_DUTY_ZERO 10'h000
`define CCPW_RESP_OK 2'b00
`define CCPW_RESP_ERR 2'b10

`endif

//--- ccpw_pkg.sv
// Types of the standard PWM unit
package ccpw_pkg;
  typedef logic [9:0] ccpw_duty_t;
  typedef enum logic [1:0] {
    CCPW_ST_OFF = 2'b00,
    CCPW_ST_HIGH = 2'b01,
    CCPW_ST_LOW = 2'b10
  } ccpw_state_e;
endpackage

//--- ccpw_duty_buf.sv
// Active duty buffer, reloaded only at period roll
`include "ccpw_defs.svh"
module ccpw_duty_buf (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire ccpw_pkg::ccpw_duty_t duty_in,
  output ccpw_pkg::ccpw_duty_t duty_q
);
  // Second stage of the double buffer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_q <= `CCPW_DUTY_ZERO;
    end else if (load) begin
      duty_q <= duty_in;
    end
  end
endmodule

//--- ccpw_top.sv
// Standard PWM unit with AXI4-Lite register access
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`include "ccpw_defs.svh"
module ccpw_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] period_timer_count,
  input wire logic period_match,
  input wire logic period_inc,
  input wire logic prescale_is_one,
  input wire logic [1:0] clock_phase,
  input wire logic [1:0] prescale_count,
  input wire logic sleep_req,
  output logic wave_output_pin_o,
  output logic wave_output_pin_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0] unit_control_register_q;
  logic [15:0] duty_value_register_q;
  logic pin_direction_control_q;
  ccpw_pkg::ccpw_state_e state_q, state_d;
  ccpw_pkg::ccpw_duty_t duty_buf;
  logic sleep_m_q, sleep_s_q;
  logic aw_full_q, w_full_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // Place the 10-bit duty by alignment select
  function automatic ccpw_pkg::ccpw_duty_t align_duty(input logic [15:0] raw,
                                                      input logic left);
    if (left) begin
      align_duty = raw[15:6];
    end else begin
      align_duty = raw[9:0];
    end
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
    merge_lanes = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge_lanes[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sleep request synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_m_q <= 1'b0;
      sleep_s_q <= 1'b0;
    end else begin
      sleep_m_q <= sleep_req;
      sleep_s_q <= sleep_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode, time base and compare
  wire duty_left = unit_control_register_q[`CCPW_FMT_BIT];
  wire pwm_on = unit_control_register_q[`CCPW_EN_BIT] &&
                (unit_control_register_q[`CCPW_MODE_HI:`CCPW_MODE_LO] == `CCPW_MODE_PWM);
  wire run = pwm_on && !sleep_s_q;
  wire [1:0] tb_low = prescale_is_one ? clock_phase : prescale_count;
  wire [9:0] time_base = {period_timer_count, tb_low};
  wire period_roll = run && period_inc && period_match;
  wire ccpw_pkg::ccpw_duty_t duty_new = align_duty(duty_value_register_q,
                                                  duty_left);
  wire duty_nz = (duty_new != `CCPW_DUTY_ZERO);
  wire duty_hit = (time_base == duty_buf);
  wire out_q = (state_q == ccpw_pkg::CCPW_ST_HIGH);

  // Double buffer of the duty value
  ccpw_duty_buf u_duty_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(period_roll),
    .duty_in(duty_new),
    .duty_q(duty_buf)
  );

  // Output level state machine
  always_comb begin
    state_d = state_q;
    if (sleep_s_q) begin
      state_d = state_q;
    end else if (!pwm_on) begin
      state_d = ccpw_pkg::CCPW_ST_OFF;
    end else begin
      case (state_q)
        ccpw_pkg::CCPW_ST_OFF, ccpw_pkg::CCPW_ST_LOW: begin
          if (period_roll) begin
            state_d = duty_nz ? ccpw_pkg::CCPW_ST_HIGH : ccpw_pkg::CCPW_ST_LOW;
          end
        end
        ccpw_pkg::CCPW_ST_HIGH: begin
          if (period_roll) begin
            state_d = duty_nz ? ccpw_pkg::CCPW_ST_HIGH : ccpw_pkg::CCPW_ST_LOW;
          end else if (duty_hit) begin
            state_d = ccpw_pkg::CCPW_ST_LOW;
          end
        end
        default: begin
          state_d = ccpw_pkg::CCPW_ST_OFF;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ccpw_pkg::CCPW_ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Pin level: set by the state register, cleared by the compare in the
  // cycle the time base reaches the duty, so the high time is exact
  assign wave_output_pin_o = out_q && !duty_hit;
  // Driver enabled only with direction cleared
  assign wave_output_pin_oe = pwm_on && !pin_direction_control_q;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  wire aw_take = s_axi_awvalid && !aw_full_q;
  wire w_take = s_axi_wvalid && !w_full_q;
  wire wr_go = aw_full_q && w_full_q && !bvalid_q;
  wire wr_ctrl = wr_go && (aw_addr_q == `CCPW_ADDR_CTRL);
  wire wr_duty = wr_go && (aw_addr_q == `CCPW_ADDR_DUTY);
  wire wr_dir = wr_go && (aw_addr_q == `CCPW_ADDR_DIR);
  wire wr_stat = wr_go && (aw_addr_q == `CCPW_ADDR_STAT);
  wire wr_ok = wr_ctrl || wr_duty || wr_dir || wr_stat;
  wire [31:0] ctrl_m = merge_lanes({24'h0, unit_control_register_q}, w_data_q, w_strb_q);
  wire [31:0] duty_m = merge_lanes({16'h0, duty_value_register_q}, w_data_q, w_strb_q);
  wire [31:0] dir_m = merge_lanes({31'h0, pin_direction_control_q}, w_data_q, w_strb_q);

  // Address and data holding, either order
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
      end else if (wr_go) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CCPW_RESP_OK;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? `CCPW_RESP_OK : `CCPW_RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Software registers; output bit of control is read-only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_control_register_q <= `CCPW_CTRL_RST;
      duty_value_register_q <= `CCPW_DUTY_RST;
      pin_direction_control_q <= `CCPW_DIR_RST;
    end else begin
      if (wr_ctrl) begin
        unit_control_register_q <= {ctrl_m[7], 2'b00, ctrl_m[4:0]};
      end
      if (wr_duty) begin
        duty_value_register_q <= duty_m[15:0];
      end
      if (wr_dir) begin
        pin_direction_control_q <= dir_m[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  wire [3:0] ra = {s_axi_araddr[3:2], 2'b00};
  wire rd_ok = (ra == `CCPW_ADDR_CTRL) || (ra == `CCPW_ADDR_DUTY) ||
               (ra == `CCPW_ADDR_DIR) || (ra == `CCPW_ADDR_STAT);
  wire [7:0] ctrl_rd = {unit_control_register_q[7], 1'b0, out_q,
                        unit_control_register_q[4:0]};
  wire [31:0] rd_mux = (ra == `CCPW_ADDR_CTRL) ? {24'h0, ctrl_rd} :
                       (ra == `CCPW_ADDR_DUTY) ? {16'h0, duty_value_register_q} :
                       (ra == `CCPW_ADDR_DIR) ? {31'h0, pin_direction_control_q} :
                       (ra == `CCPW_ADDR_STAT) ?
                         {13'h0, sleep_s_q, pwm_on, out_q, 6'h0, duty_buf} :
                       32'h0;

  // Read answer one cycle after address
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `CCPW_RESP_OK;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? `CCPW_RESP_OK : `CCPW_RESP_ERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_roll_sets_pin: assert property (period_roll && duty_nz |=> wave_output_pin_o)
    else $error("pin not set at period roll");
  a_zero_duty_low: assert property (period_roll && !duty_nz |=> !wave_output_pin_o)
    else $error("pin set with zero duty");
  a_buffer_loads: assert property (period_roll |=> duty_buf == $past(duty_new))
    else $error("duty buffer not loaded at roll");
  a_buffer_holds: assert property (!period_roll |=> $stable(duty_buf))
    else $error("duty buffer changed outside roll");
  a_match_clears: assert property (run && out_q && duty_hit && !period_roll
                                   |=> !wave_output_pin_o)
    else $error("pin not cleared at duty match");
  a_rise_only_roll: assert property ($rose(wave_output_pin_o) |-> $past(period_roll))
    else $error("pin rose without period roll");
  a_sleep_freeze: assert property (sleep_s_q |=> $stable(state_q) && $stable(duty_buf))
    else $error("state moved during sleep");
  a_off_mode_low: assert property (!pwm_on && !sleep_s_q |=> !wave_output_pin_o)
    else $error("pin high while unit off");
  a_driver_gate: assert property (wave_output_pin_oe |-> !pin_direction_control_q && pwm_on)
    else $error("driver on with direction set");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  // Alignment, compare and sleep hold
  a_align_left: assert property (period_roll && duty_left |=>
                                 duty_buf == $past(duty_value_register_q[15:6]))
    else $error("left aligned duty not loaded");
  a_align_right: assert property (period_roll && !duty_left |=>
                                  duty_buf == $past(duty_value_register_q[9:0]))
    else $error("right aligned duty not loaded");
  a_hit_drops_pin: assert property (out_q && duty_hit |-> !wave_output_pin_o)
    else $error("pin high at duty match");
  a_sleep_pin_hold: assert property (sleep_s_q && $past(sleep_s_q) |->
                                     $stable(wave_output_pin_o))
    else $error("pin moved during sleep");

  c_roll: cover property (period_roll ##[1:300] (run && out_q && duty_hit));
  c_sleep: cover property (sleep_s_q && out_q);
  c_write: cover property (wr_duty ##[1:50] period_roll);
  c_zero_duty: cover property (period_roll && !duty_nz);
endmodule

//--- ccpw_tmr_model.sv
// Period timer partner model feeding the standard PWM unit
module ccpw_tmr_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic timer_run_bit,
  input wire logic timer_prescale_select,
  input wire logic sleep_req,
  input wire logic [7:0] period_limit_register,
  output logic [7:0] period_timer_count,
  output logic period_match,
  output logic period_inc,
  output logic prescale_is_one,
  output logic [1:0] clock_phase,
  output logic [1:0] prescale_count,
  output logic timer_overflow_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ph_q;
  logic sleep_m_q, sleep_s_q;
  //////////////////////////////////////////////////
  // Phase bits and increment strobe, one step per four clocks, or per sixteen with prescale select set
  assign clock_phase = ph_q[1:0];
  assign prescale_count = ph_q[3:2];
  assign prescale_is_one = !timer_prescale_select;
  assign period_match = period_timer_count == period_limit_register;
  assign period_inc = timer_run_bit && !sleep_s_q &&
    (timer_prescale_select ? ph_q == 4'hf : ph_q[1:0] == 2'h3);
  // Sleep synchroniser matched to the unit's, so both freeze on one edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_m_q <= 1'b0;
      sleep_s_q <= 1'b0;
    end else begin
      sleep_m_q <= sleep_req;
      sleep_s_q <= sleep_m_q;
    end
  end
  // Count and flag; no postscaler, frozen while asleep
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= 4'h0;
      period_timer_count <= 8'h00;
      timer_overflow_flag <= 1'b0;
    end else if (!timer_run_bit) begin
      ph_q <= 4'h0;
      period_timer_count <= 8'h00;
      timer_overflow_flag <= 1'b0;
    end else if (!sleep_s_q) begin
      ph_q <= ph_q + 4'h1;
      if (period_inc) period_timer_count <= period_match ? 8'h00 : period_timer_count + 8'h01;
      if (period_inc && period_match) timer_overflow_flag <= 1'b1;
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the standard PWM unit
`include "ccpw_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic fmt;
    logic [9:0] duty;
    logic [7:0] lim;
    logic pre;
    logic [15:0] hi;
    logic [15:0] per;
  } ccpw_row_s;
  logic sys_clk = 1'b0, rst_n = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0;
  logic ar_v = 1'b0, r_rdy = 1'b0, sleep_req = 1'b0, run = 1'b0, pre = 1'b0;
  logic [3:0] aw_a = 4'h0, ar_a = 4'h0;
  logic [31:0] w_d = 32'h0, rd, r_d;
  logic [7:0] lim = 8'h03, cnt;
  logic aw_r, w_r, b_v, ar_r, r_v, pin_o, pin_oe, inc, match, one, flag;
  logic [1:0] b_resp, r_resp, cph, pcnt;
  int mismatches = 0, check_count = 0, hi, per, n, i;
  // High = prescale * duty, period = 4 * prescale * (limit + 1)
  ccpw_row_s rows [5] = '{
    '{1'b0, 10'd5, 8'h03, 1'b0, 16'd5, 16'd16},
    '{1'b1, 10'd10, 8'h07, 1'b0, 16'd10, 16'd32},
    '{1'b0, 10'd14, 8'h03, 1'b0, 16'd14, 16'd16},
    '{1'b0, 10'd3, 8'h03, 1'b1, 16'd12, 16'd64},
    '{1'b1, 10'd512, 8'hff, 1'b0, 16'd512, 16'd1024}};
  always #5 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////
  // Unit under test and its period timer
  ccpw_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_rdy),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
    .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_rdy), .period_timer_count(cnt),
    .period_match(match), .period_inc(inc), .prescale_is_one(one), .clock_phase(cph),
    .prescale_count(pcnt), .sleep_req(sleep_req), .wave_output_pin_o(pin_o),
    .wave_output_pin_oe(pin_oe));
  ccpw_tmr_model u_tmr (.sys_clk(sys_clk), .rst_n(rst_n), .timer_run_bit(run),
    .timer_prescale_select(pre), .sleep_req(sleep_req), .period_limit_register(lim),
    .period_timer_count(cnt), .period_match(match), .period_inc(inc), .prescale_is_one(one),
    .clock_phase(cph), .prescale_count(pcnt), .timer_overflow_flag(flag));
  //////////////////////////////////////////////////
  // Compare, verdict and hang exit
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang();
    $display("wait limit hit at %0t", $time);
    mismatches++;
    report_and_stop();
  endtask
  // Bus cycles: hold each channel until its ready
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int k;
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    for (k = 0; k < 50 && !(b_v && b_rdy); k++) begin
      @(posedge sys_clk);
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
    end
    b_rdy <= 1'b0;
    check({30'h0, b_resp}, {30'h0, `CCPW_RESP_OK});
    if (k == 50) hang();
    @(posedge sys_clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    int k;
    ar_a <= a;
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    for (k = 0; k < 50 && !(r_v && r_rdy); k++) begin
      @(posedge sys_clk);
      if (ar_v && ar_r) ar_v <= 1'b0;
    end
    d = r_d;
    r_rdy <= 1'b0;
    check({30'h0, r_resp}, {30'h0, `CCPW_RESP_OK});
    if (k == 50) hang();
    @(posedge sys_clk);
  endtask
  // Waveform measurement over one full period, ending on the next period's first high sample
  task automatic measure(output int h, output int p);
    int k;
    h = 0;
    k = 0;
    @(negedge sys_clk);
    while (pin_o !== 1'b0 && k < 4000) begin @(negedge sys_clk); k++; end
    while (pin_o !== 1'b1 && k < 4000) begin @(negedge sys_clk); k++; end
    while (pin_o === 1'b1 && k < 4000) begin @(negedge sys_clk); k++; h++; end
    p = h;
    while (pin_o !== 1'b1 && k < 4000) begin @(negedge sys_clk); k++; p++; end
    if (k >= 4000) hang();
  endtask
  task automatic hold_high(output int h);
    h = 0;
    repeat (48) begin
      @(negedge sys_clk);
      h += (pin_o === 1'b1);
    end
    @(posedge sys_clk);
  endtask
  // Setup order: timer stop, period, driver off, mode, duty, timer, flag, driver on
  task automatic cfg(input ccpw_row_s r);
    int k;
    @(posedge sys_clk);
    run <= 1'b0;
    lim <= r.lim;
    pre <= r.pre;
    wr(`CCPW_ADDR_DIR, 32'h1);
    wr(`CCPW_ADDR_CTRL, {24'h0, 3'b100, r.fmt, 4'hc});
    wr(`CCPW_ADDR_DUTY, r.fmt ? {16'h0, r.duty, 6'h15} : {16'h0, 6'h2a, r.duty});
    run <= 1'b1;
    for (k = 0; k < 3000 && flag !== 1'b1; k++) @(posedge sys_clk);
    if (k == 3000) hang();
    wr(`CCPW_ADDR_DIR, 32'h0);
    check({31'h0, pin_oe}, 32'h1);
  endtask
  task automatic defaults();
    check({30'h0, pin_o, pin_oe}, 32'h0);
    rd_reg(`CCPW_ADDR_CTRL, rd);
    check(rd & 32'hff, 32'h0);
    rd_reg(`CCPW_ADDR_DUTY, rd);
    check(rd & 32'hffff, 32'h0);
    rd_reg(`CCPW_ADDR_DIR, rd);
    check(rd & 32'h1, 32'h1);
  endtask
  //////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    defaults();
    for (i = 0; i < 5; i++) begin
      cfg(rows[i]);
      measure(hi, per);
      check(hi, rows[i].hi);
      check(per, rows[i].per);
      $display("row %0d done", i);
    end
    // Duty write in mid-cycle takes effect at the next roll
    cfg('{1'b0, 10'd100, 8'h3f, 1'b0, 16'd0, 16'd0});
    measure(hi, per);
    fork
      begin @(posedge sys_clk); wr(`CCPW_ADDR_DUTY, 32'd40); end
      for (n = 1; n < 300 && pin_o === 1'b1; n++) @(negedge sys_clk);
    join
    check(n - 1, 32'd100);
    measure(hi, per);
    check(hi, 32'd40);
    @(posedge sys_clk);
    rd_reg(`CCPW_ADDR_STAT, rd);
    check(rd & 32'h3ff, 32'd40);
    $display("buffer test done");
    // Duty beyond span, then zero duty
    cfg('{1'b0, 10'h020, 8'h03, 1'b0, 16'd0, 16'd0});
    hold_high(hi);
    check(hi, 32'd48);
    cfg('{1'b0, 10'h000, 8'h03, 1'b0, 16'd0, 16'd0});
    hold_high(hi);
    check(hi, 32'd0);
    $display("span test done");
    // Sleep freezes the pin, bus stays live
    cfg('{1'b1, 10'd6, 8'h03, 1'b0, 16'd0, 16'd0});
    sleep_req <= 1'b1;
    repeat (3) @(negedge sys_clk);
    n = (pin_o === 1'b1) ? 48 : 0;
    hold_high(hi);
    check(hi, n);
    rd_reg(`CCPW_ADDR_STAT, rd);
    check({31'h0, rd[18]}, 32'h1);
    sleep_req <= 1'b0;
    measure(hi, per);
    check(hi, 32'd6);
    $display("sleep test done");
    // Every mode code, then enable off
    @(posedge sys_clk);
    for (i = 0; i < 16; i++) begin
      wr(`CCPW_ADDR_CTRL, 32'h80 | i);
      rd_reg(`CCPW_ADDR_STAT, rd);
      check({31'h0, rd[17]}, {31'h0, i[3:2] == 2'b11});
    end
    wr(`CCPW_ADDR_CTRL, 32'h0c);
    hold_high(hi);
    check(hi, 32'd0);
    $display("mode test done");
    // Reset in mid-run
    cfg(rows[0]);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    defaults();
    $display("reset test done");
    report_and_stop();
  end
endmodule
